/* design/lbo_pkg.sv */
// shared constants and types for the limit-test binning output block
// assumes a 20 MHz clock and a classic wishbone register bus with 32-bit data
package lbo_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int STEP_US       = 10;
    localparam int LEAD_US       = 10;
    localparam int EXTRA_US      = 20;
    localparam int WIDTH_MAX_S   = 60;
    localparam int STEP_CYC  = (STEP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LEAD_CYC  = (LEAD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EXTRA_CYC = (EXTRA_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [22:0] WIDTH_MAX_STEPS = 23'(WIDTH_MAX_S * (1000000 / STEP_US));

    ////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_PAT    = 8'h04;
    localparam logic [7:0] OFS_WIDTH  = 8'h08;
    localparam logic [7:0] OFS_LOC    = 8'h0c;
    localparam logic [7:0] OFS_STAT   = 8'h10;
    localparam logic [3:0] BAND_BASE  = 4'h2;
    localparam logic [1:0] BAND_EN    = 2'h0;
    localparam logic [1:0] BAND_LOW   = 2'h1;
    localparam logic [1:0] BAND_HIGH  = 2'h2;
    localparam logic [1:0] BAND_PATS  = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // control field positions
    localparam int CB_SIZE4    = 0;
    localparam int CB_SORT     = 1;
    localparam int CB_BIN_END  = 2;
    localparam int CB_COMP_OUT = 3;
    localparam int CB_ACLR     = 4;
    localparam int CB_L4       = 5;
    localparam int CB_ARM      = 7;
    localparam int CB_COMP_EN  = 9;
    localparam int CB_CONT_EN  = 10;
    localparam int CB_NEXT     = 11;
    localparam int CB_START    = 12;
    localparam int CB_CLEAR    = 13;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
    localparam logic [31:0] PAT_RST   = 32'h0000_0000;
    localparam logic [22:0] WIDTH_RST = 23'h00_0001;
    localparam logic [6:0]  LOC_RST   = 7'h01;
    localparam logic [6:0]  LOC_MAX   = 7'h64;

    ////////////////////////////////////////////////////////////////////////////
    // types
    localparam int VALUE_W = 32;

    typedef enum logic [1:0] {
        L4_STROBE_HI, L4_STROBE_LO, L4_BUSY_HI, L4_BUSY_LO
    } lbo_l4_type;

    typedef enum logic [1:0] {
        ARM_LOCAL, ARM_FALL, ARM_RISE, ARM_BOTH
    } lbo_arm_type;

    typedef struct packed {
        logic               valid;
        logic               last;
        logic               in_compliance;
        logic               contact_fail;
        logic [VALUE_W-1:0] value;
    } lbo_meas_type;

    typedef struct packed {
        logic       valid;
        logic       next;
        logic [6:0] loc;
    } lbo_branch_type;

endpackage

/* design/lbo_binning_output.sv */
// limit-test binning: grades or sorts readings and drives the handler output lines
// assumes readings arrive as one-cycle strobes and handler inputs are synchronous
module lbo_binning_output #(
    parameter int NBANDS = 10
) (
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // wishbone slave
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [31:0]           wb_dat_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic                  wb_we_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_cyc_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    // handler lines
    input  wire logic                  test_start_input_i,
    output logic      [3:0]            out_lines_o,
    // measurement side
    input  wire lbo_pkg::lbo_meas_type meas_i,
    output logic                       test_run_o,
    output lbo_pkg::lbo_branch_type    branch_o
);

    typedef enum logic [1:0] {ST_IDLE, ST_TEST, ST_SHOW} lbo_state_type;

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic                 ack_r;
    logic [31:0]          dat_r;
    logic                 size4_r, sort_r, bin_end_r, comp_out_r, aclr_r;
    lbo_pkg::lbo_l4_type  l4_r;
    lbo_pkg::lbo_arm_type arm_r;
    logic                 comp_en_r, cont_en_r, next_r;
    logic [3:0]           pass_pat_r, clr_pat_r, comp_pat_r, cont_pat_r, sfail_pat_r;
    logic [22:0]          width_r;
    logic [6:0]           loc_r;
    logic                 band_en_r  [NBANDS];
    logic [31:0]          band_lo_r  [NBANDS];
    logic [31:0]          band_hi_r  [NBANDS];
    logic [7:0]           band_pat_r [NBANDS];
    lbo_state_type        state_r, state_nxt;
    logic                 sot_q_r;
    logic                 fail_seen_r;
    logic [3:0]           res_pat_r, res_pat_nxt;
    logic [31:0]          cnt_r;
    logic [3:0]           out_r, out_nxt;
    logic                 run_r;
    lbo_pkg::lbo_branch_type branch_r, branch_nxt;

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    wire        req_w      = wb_cyc_i && wb_stb_i && !ack_r;
    wire        wr_w       = req_w && wb_we_i;
    wire        hit_ctrl_w = wb_adr_i == lbo_pkg::OFS_CTRL;
    wire        hit_pat_w  = wb_adr_i == lbo_pkg::OFS_PAT;
    wire        hit_wid_w  = wb_adr_i == lbo_pkg::OFS_WIDTH;
    wire        hit_loc_w  = wb_adr_i == lbo_pkg::OFS_LOC;
    wire        hit_stat_w = wb_adr_i == lbo_pkg::OFS_STAT;
    wire [3:0]  bidx_w     = wb_adr_i[7:4] - lbo_pkg::BAND_BASE;
    wire        band_hit_w = (wb_adr_i[7:4] >= lbo_pkg::BAND_BASE)
                             && ({1'b0, bidx_w} < 5'(NBANDS));
    wire [1:0]  bword_w    = wb_adr_i[3:2];
    wire        aligned_w  = wb_adr_i[1:0] == 2'h0;

    wire [31:0] ctrl_rd_w = {18'h0, 2'h0, next_r, cont_en_r, comp_en_r, arm_r, l4_r,
                             aclr_r, comp_out_r, bin_end_r, sort_r, size4_r};
    wire [31:0] pat_rd_w  = {12'h0, sfail_pat_r, cont_pat_r, comp_pat_r, clr_pat_r, pass_pat_r};
    wire [31:0] ctrl_wr_w = merge(ctrl_rd_w, wb_dat_i, wb_sel_i);
    wire [31:0] pat_wr_w  = merge(pat_rd_w, wb_dat_i, wb_sel_i);
    wire [31:0] wid_wr_w  = merge({9'h0, width_r}, wb_dat_i, wb_sel_i);
    wire [31:0] loc_wr_w  = merge({25'h0, loc_r}, wb_dat_i, wb_sel_i);
    wire        ctrl_wr   = wr_w && hit_ctrl_w;
    wire        start_cmd_w = ctrl_wr && ctrl_wr_w[lbo_pkg::CB_START];
    wire        clear_cmd_w = ctrl_wr && ctrl_wr_w[lbo_pkg::CB_CLEAR];

    // width limited to the 60 s span, location to 1..100
    wire [22:0] wid_new_w = (wid_wr_w[31:23] != 9'h0 || wid_wr_w[22:0] > lbo_pkg::WIDTH_MAX_STEPS)
                            ? lbo_pkg::WIDTH_MAX_STEPS : wid_wr_w[22:0];
    wire [6:0]  loc_new_w = (loc_wr_w[31:7] != 25'h0 || loc_wr_w[6:0] > lbo_pkg::LOC_MAX)
                            ? lbo_pkg::LOC_MAX
                            : (loc_wr_w[6:0] == 7'h00 ? 7'h01 : loc_wr_w[6:0]);

    wire [31:0] band_rd_w = !band_hit_w ? 32'h0 :
                            bword_w == lbo_pkg::BAND_EN   ? {31'h0, band_en_r[bidx_w]} :
                            bword_w == lbo_pkg::BAND_LOW  ? band_lo_r[bidx_w] :
                            bword_w == lbo_pkg::BAND_HIGH ? band_hi_r[bidx_w] :
                                                            {24'h0, band_pat_r[bidx_w]};
    wire [31:0] stat_rd_w = {20'h0, out_r, res_pat_r, fail_seen_r, run_r, state_r};
    wire [31:0] rd_w      = !aligned_w ? 32'h0 :
                            hit_ctrl_w ? ctrl_rd_w :
                            hit_pat_w  ? pat_rd_w :
                            hit_wid_w  ? {9'h0, width_r} :
                            hit_loc_w  ? {25'h0, loc_r} :
                            hit_stat_w ? stat_rd_w : band_rd_w;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0;
        end else begin
            ack_r <= req_w;
            dat_r <= req_w ? rd_w : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            size4_r     <= lbo_pkg::CTRL_RST[lbo_pkg::CB_SIZE4];
            sort_r      <= lbo_pkg::CTRL_RST[lbo_pkg::CB_SORT];
            bin_end_r   <= lbo_pkg::CTRL_RST[lbo_pkg::CB_BIN_END];
            comp_out_r  <= lbo_pkg::CTRL_RST[lbo_pkg::CB_COMP_OUT];
            aclr_r      <= lbo_pkg::CTRL_RST[lbo_pkg::CB_ACLR];
            l4_r        <= lbo_pkg::L4_STROBE_HI;
            arm_r       <= lbo_pkg::ARM_LOCAL;
            comp_en_r   <= lbo_pkg::CTRL_RST[lbo_pkg::CB_COMP_EN];
            cont_en_r   <= lbo_pkg::CTRL_RST[lbo_pkg::CB_CONT_EN];
            next_r      <= lbo_pkg::CTRL_RST[lbo_pkg::CB_NEXT];
            {sfail_pat_r, cont_pat_r, comp_pat_r, clr_pat_r, pass_pat_r} <= lbo_pkg::PAT_RST[19:0];
            width_r     <= lbo_pkg::WIDTH_RST;
            loc_r       <= lbo_pkg::LOC_RST;
        end else begin
            if (ctrl_wr && aligned_w) begin
                size4_r    <= ctrl_wr_w[lbo_pkg::CB_SIZE4];
                sort_r     <= ctrl_wr_w[lbo_pkg::CB_SORT];
                bin_end_r  <= ctrl_wr_w[lbo_pkg::CB_BIN_END];
                comp_out_r <= ctrl_wr_w[lbo_pkg::CB_COMP_OUT];
                aclr_r     <= ctrl_wr_w[lbo_pkg::CB_ACLR];
                l4_r       <= lbo_pkg::lbo_l4_type'(ctrl_wr_w[lbo_pkg::CB_L4 +: 2]);
                arm_r      <= lbo_pkg::lbo_arm_type'(ctrl_wr_w[lbo_pkg::CB_ARM +: 2]);
                comp_en_r  <= ctrl_wr_w[lbo_pkg::CB_COMP_EN];
                cont_en_r  <= ctrl_wr_w[lbo_pkg::CB_CONT_EN];
                next_r     <= ctrl_wr_w[lbo_pkg::CB_NEXT];
            end
            if (wr_w && hit_pat_w) begin
                {sfail_pat_r, cont_pat_r, comp_pat_r, clr_pat_r, pass_pat_r} <= pat_wr_w[19:0];
            end
            if (wr_w && hit_wid_w) begin
                width_r <= wid_new_w;
            end
            if (wr_w && hit_loc_w) begin
                loc_r <= loc_new_w;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software bands: storage and per-band comparison
    logic [NBANDS-1:0] hi_fail_w, lo_fail_w, in_band_w, band_on_w;
    wire signed [lbo_pkg::VALUE_W-1:0] val_w = $signed(meas_i.value);

    for (genvar b = 0; b < NBANDS; b++) begin : g_band
        wire wr_b = wr_w && band_hit_w && aligned_w && bidx_w == 4'(b);
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                band_en_r[b]  <= 1'b0;
                band_lo_r[b]  <= 32'h0;
                band_hi_r[b]  <= 32'h0;
                band_pat_r[b] <= 8'h00;
            end else if (wr_b) begin
                if (bword_w == lbo_pkg::BAND_EN && wb_sel_i[0]) begin
                    band_en_r[b] <= wb_dat_i[0];
                end
                if (bword_w == lbo_pkg::BAND_LOW) begin
                    band_lo_r[b] <= merge(band_lo_r[b], wb_dat_i, wb_sel_i);
                end
                if (bword_w == lbo_pkg::BAND_HIGH) begin
                    band_hi_r[b] <= merge(band_hi_r[b], wb_dat_i, wb_sel_i);
                end
                if (bword_w == lbo_pkg::BAND_PATS && wb_sel_i[0]) begin
                    band_pat_r[b] <= wb_dat_i[7:0];
                end
            end
        end
        assign band_on_w[b] = band_en_r[b];
        assign hi_fail_w[b] = band_en_r[b] && (val_w > $signed(band_hi_r[b]));
        assign lo_fail_w[b] = band_en_r[b] && (val_w < $signed(band_lo_r[b]));
        assign in_band_w[b] = band_en_r[b] && !hi_fail_w[b] && !lo_fail_w[b];
    end

    ////////////////////////////////////////////////////////////////////////////
    // evaluation of one reading
    logic       g_hit, s_hit;
    logic [3:0] g_pat, s_pat;

    always_comb begin
        g_hit = 1'b0;
        g_pat = 4'h0;
        s_hit = 1'b0;
        s_pat = 4'h0;
        for (int b = NBANDS - 1; b >= 0; b--) begin
            if (hi_fail_w[b]) begin
                g_hit = 1'b1;
                g_pat = band_pat_r[b][7:4];
            end else if (lo_fail_w[b]) begin
                g_hit = 1'b1;
                g_pat = band_pat_r[b][3:0];
            end
            if (in_band_w[b]) begin
                s_hit = 1'b1;
                s_pat = band_pat_r[b][3:0];
            end
        end
    end

    wire comp_f_w  = comp_en_r && (comp_out_r ? !meas_i.in_compliance
                                              : meas_i.in_compliance);
    wire cont_f_w  = cont_en_r && meas_i.contact_fail;
    wire any_en_w  = |band_on_w;
    wire grade_f_w = cont_f_w || comp_f_w || g_hit;
    wire [3:0] grade_pat_w = cont_f_w ? cont_pat_r :
                             comp_f_w ? comp_pat_r :
                             g_hit    ? g_pat : pass_pat_r;
    wire sort_f_w  = cont_f_w || comp_f_w || (any_en_w && !s_hit);
    wire [3:0] sort_pat_w  = cont_f_w  ? cont_pat_r :
                             comp_f_w  ? comp_pat_r :
                             !any_en_w ? pass_pat_r :
                             s_hit     ? s_pat : sfail_pat_r;
    wire       pt_fail_w = sort_r ? sort_f_w : grade_f_w;
    wire [3:0] pt_pat_w  = sort_r ? sort_pat_w : grade_pat_w;

    ////////////////////////////////////////////////////////////////////////////
    // start arming
    wire busy_mode_w = (l4_r == lbo_pkg::L4_BUSY_HI) || (l4_r == lbo_pkg::L4_BUSY_LO);
    wire size3_w     = !size4_r || busy_mode_w;
    wire sot_fall_w  = sot_q_r && !test_start_input_i;
    wire sot_rise_w  = !sot_q_r && test_start_input_i;
    logic start_w;

    always_comb begin
        case (arm_r)
            lbo_pkg::ARM_LOCAL: start_w = busy_mode_w ? sot_fall_w : start_cmd_w;
            lbo_pkg::ARM_FALL:  start_w = sot_fall_w;
            lbo_pkg::ARM_RISE:  start_w = sot_rise_w;
            lbo_pkg::ARM_BOTH:  start_w = sot_fall_w || sot_rise_w;
            default:            start_w = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // test sequence
    wire [31:0] wcyc_w  = 32'(width_r) * 32'(lbo_pkg::STEP_CYC);
    wire [31:0] end_w   = wcyc_w + 32'(lbo_pkg::EXTRA_CYC);
    wire        stop_w  = meas_i.valid && (meas_i.last
                          || (pt_fail_w && !bin_end_r && !sort_r));
    wire        strobe_w = (state_r == ST_SHOW) && aclr_r
                          && cnt_r >= 32'(lbo_pkg::LEAD_CYC)
                          && cnt_r < 32'(lbo_pkg::LEAD_CYC) + wcyc_w;

    always_comb begin
        state_nxt   = state_r;
        res_pat_nxt = res_pat_r;
        branch_nxt  = '0;
        case (state_r)
            ST_IDLE: begin
                if (start_w) begin
                    state_nxt = ST_TEST;
                end
            end
            ST_TEST: begin
                if (meas_i.valid) begin
                    if (!fail_seen_r) begin
                        res_pat_nxt = pt_pat_w;
                    end
                    if (!pt_fail_w) begin
                        branch_nxt.valid = 1'b1;
                        branch_nxt.next  = next_r;
                        branch_nxt.loc   = loc_r;
                    end
                end
                if (stop_w) begin
                    state_nxt = ST_SHOW;
                end
            end
            ST_SHOW: begin
                if (aclr_r && cnt_r >= end_w) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        if (clear_cmd_w) begin
            state_nxt = ST_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output lines
    always_comb begin
        out_nxt[2:0] = (state_nxt == ST_SHOW) ? res_pat_nxt[2:0] : clr_pat_r[2:0];
        if (!size3_w) begin
            out_nxt[3] = (state_nxt == ST_SHOW) ? res_pat_nxt[3] : clr_pat_r[3];
        end else begin
            case (l4_r)
                lbo_pkg::L4_STROBE_HI: out_nxt[3] = strobe_w;
                lbo_pkg::L4_STROBE_LO: out_nxt[3] = !strobe_w;
                lbo_pkg::L4_BUSY_HI:   out_nxt[3] = state_nxt == ST_TEST;
                lbo_pkg::L4_BUSY_LO:   out_nxt[3] = state_nxt != ST_TEST;
                default:               out_nxt[3] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r     <= ST_IDLE;
            sot_q_r     <= 1'b1;
            fail_seen_r <= 1'b0;
            res_pat_r   <= 4'h0;
            cnt_r       <= 32'h0;
            out_r       <= 4'h0;
            run_r       <= 1'b0;
            branch_r    <= '0;
        end else begin
            state_r     <= state_nxt;
            sot_q_r     <= test_start_input_i;
            res_pat_r   <= res_pat_nxt;
            out_r       <= out_nxt;
            run_r       <= state_nxt == ST_TEST;
            branch_r    <= branch_nxt;
            cnt_r       <= (state_r == ST_SHOW && state_nxt == ST_SHOW) ? cnt_r + 32'h1 : 32'h0;
            if (state_r == ST_IDLE) begin
                fail_seen_r <= 1'b0;
            end else if (state_r == ST_TEST && meas_i.valid && pt_fail_w) begin
                fail_seen_r <= 1'b1;
            end
        end
    end

    assign wb_ack_o    = ack_r;
    assign wb_dat_o    = dat_r;
    assign out_lines_o = out_r;
    assign test_run_o  = run_r;
    assign branch_o    = branch_r;

endmodule

/* dv/lbo_binning_output_assertions.sv */
// port checker for the binning output block
// assumes a bind from the testbench top file
module lbo_binning_output_assertions (
    input wire logic                    clk_i,
    input wire logic                    rst_i,
    input wire logic                    wb_stb_i,
    input wire logic                    wb_cyc_i,
    input wire logic [31:0]             wb_dat_o,
    input wire logic                    wb_ack_o,
    input wire logic [3:0]              out_lines_o,
    input wire lbo_pkg::lbo_meas_type   meas_i,
    input wire logic                    test_run_o,
    input wire lbo_pkg::lbo_branch_type branch_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_reset_clear: assert property ($fell(rst_i) |-> out_lines_o == 4'h0 && !test_run_o)
        else $error("lines not clear after reset");
    a_run_stops: assert property (test_run_o && meas_i.valid && meas_i.last |=> !test_run_o)
        else $error("test did not stop on last reading");
    a_lines_hold: assert property (test_run_o && $past(test_run_o) |-> $stable(out_lines_o[2:0]))
        else $error("pattern changed during test");
    a_branch_cause: assert property (branch_o.valid |-> $past(meas_i.valid) && $past(test_run_o))
        else $error("branch without reading");
    a_branch_loc: assert property (branch_o.valid && !branch_o.next |->
        branch_o.loc >= 7'h01 && branch_o.loc <= 7'h64)
        else $error("branch location out of range");
endmodule

/* dv/lbo_handler_model.sv */
// handler model: drives the start-of-test line, idle high
// assumes the bench calls pulse_start when a device is in place
module lbo_handler_model (
    // clock
    input  wire logic clk_i,
    // start line
    output logic      test_start_input_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial test_start_input_o = 1'h1;
    task automatic pulse_start();
        @(posedge clk_i);
        test_start_input_o <= 1'h0;
        repeat (2) @(posedge clk_i);
        test_start_input_o <= 1'h1;
    endtask
endmodule

/* dv/testbench.sv */
// self-checking bench for the binning output block
// assumes a 20 MHz clock and the handler model on the start line
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic                    clk_i = 1'h0, rst_i = 1'h1, wb_we_i = 1'h0, wb_stb_i = 1'h0;
    logic                    wb_cyc_i = 1'h0, test_start_input_i, wb_ack_o, test_run_o, p;
    logic [7:0]              wb_adr_i = 8'h0;
    logic [31:0]             wb_dat_i = 32'h0, wb_dat_o, rd, seed = 32'h5f, c;
    logic [3:0]              out_lines_o, e;
    lbo_pkg::lbo_meas_type   meas_i = '0;
    lbo_pkg::lbo_branch_type branch_o, br;
    int                      fails = 0, comparisons = 0, cycles = 0, v;
    logic [39:0] bw [8] = '{40'h20_00000001, 40'h24_0000000a, 40'h28_00000014, 40'h2c_00000063,
                            40'h30_00000001, 40'h34_0000000f, 40'h38_0000001e, 40'h3c_00000087};
    lbo_binning_output dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(4'hf), .wb_we_i(wb_we_i), .wb_stb_i(wb_stb_i),
        .wb_cyc_i(wb_cyc_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .meas_i(meas_i),
        .test_start_input_i(test_start_input_i), .out_lines_o(out_lines_o),
        .test_run_o(test_run_o), .branch_o(branch_o));
    lbo_handler_model hnd (.clk_i(clk_i), .test_start_input_o(test_start_input_i));
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            fails++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [3:0] model(logic srt, logic co, int x, logic ic, logic ct);
        if (ct) return 4'hc;
        if (ic ^ co) return 4'h9;
        if (!srt) return x > 20 ? 4'h6 : x < 10 ? 4'h3 : x > 30 ? 4'h8 : x < 15 ? 4'h7 : 4'h1;
        return x >= 10 && x <= 20 ? 4'h3 : x >= 15 && x <= 30 ? 4'h7 : 4'he;
    endfunction
    task automatic chk(string n, logic [31:0] ex, logic [31:0] s);
        comparisons++;
        if (ex !== s) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, ex, s);
        end
    endtask
    task automatic wb(logic we, logic [7:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'h1 && ++n < 50);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        chk("ack", 1, wb_ack_o);
    endtask
    task automatic start(logic [31:0] ctl);
        int n;
        n = 0;
        wb(1'h1, 8'h00, ctl | 32'h2000);
        if (ctl[6] || ctl[8:7] != 2'h0) hnd.pulse_start();
        else wb(1'h1, 8'h00, ctl | 32'h1000);
        do begin @(posedge clk_i); #1; end while (test_run_o !== 1'h1 && ++n < 20);
        chk("run", 1, test_run_o);
    endtask
    task automatic send(int x, logic ic, logic ct, logic l);
        @(posedge clk_i);
        meas_i <= {1'h1, l, ic, ct, 32'(x)};
        @(posedge clk_i);
        meas_i <= '0;
        #1 br = branch_o;
        @(posedge clk_i);
        #1;
    endtask
    task automatic close_out();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'h0;
        #1 chk("lines", 0, out_lines_o);
        wb(1'h0, 8'h08, 32'h0); chk("width", 1, rd);
        wb(1'h0, 8'h14, 32'h0); chk("unmapped", 0, rd);
        wb(1'h1, 8'h04, 32'h000e_c901);
        wb(1'h1, 8'h0c, 32'h25);
        for (int i = 0; i < 8; i++) wb(1'h1, bw[i][39:32], bw[i][31:0]);
        for (int i = 0; i < 160; i++) begin
            seed = xs(seed);
            v = int'(seed % 32'd36);
            c = 32'h601 | {28'h0, i[1], 1'h0, i[0], 1'h0};
            e = model(i[0], i[1], v, seed[8], seed[9] & seed[10]);
            p = i[0] ? (e == 4'h3 || e == 4'h7) : e == 4'h1;
            start(c);
            send(v, seed[8], seed[9] & seed[10], 1'h1);
            chk("lines", e, out_lines_o);
            chk("branch", p, br.valid);
            if (p) chk("loc", 7'h25, br.loc);
        end
        start(32'h601);
        send(40, 1'h0, 1'h0, 1'h0);
        chk("run", 0, test_run_o);
        chk("lines", 6, out_lines_o);
        start(32'h605);
        send(40, 1'h0, 1'h0, 1'h0);
        chk("run", 1, test_run_o);
        send(17, 1'h0, 1'h0, 1'h1);
        chk("lines", 6, out_lines_o);
        wb(1'h1, 8'h20, 32'h0);
        wb(1'h1, 8'h30, 32'h0);
        start(32'h603);
        send(40, 1'h0, 1'h0, 1'h1);
        chk("lines", 1, out_lines_o);
        for (int a = 1; a < 4; a++) begin
            start(32'h601 | (a << 7));
            send(5, 1'h0, 1'h0, 1'h1);
            chk("armed", 1, out_lines_o);
        end
        for (int m = 2; m < 4; m++) begin
            start(32'h600 | (m << 5));
            chk("busy", m == 2, out_lines_o[3]);
            send(5, 1'h0, 1'h0, 1'h1);
            chk("busy", m != 2, out_lines_o[3]);
            chk("lines", 1, out_lines_o[2:0]);
        end
        wb(1'h1, 8'h04, 32'h000e_c961);
        for (int m = 0; m < 2; m++) begin
            start(32'h610 | (m << 5));
            send(5, 1'h0, 1'h0, 1'h1);
            repeat (300) @(posedge clk_i);
            #1 chk("strobe", {m == 0, 3'h1}, out_lines_o);
            repeat (200) @(posedge clk_i);
            #1 chk("skew", {m != 0, 3'h1}, out_lines_o);
            repeat (200) @(posedge clk_i);
            #1 chk("clear", 6, out_lines_o[2:0]);
        end
        close_out();
    end
endmodule
bind lbo_binning_output lbo_binning_output_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .out_lines_o(out_lines_o), .meas_i(meas_i), .test_run_o(test_run_o), .branch_o(branch_o));
